// [verilog/cbac_pkg.sv]
package cbac_pkg;

   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int CMD_W = 5;
   localparam int LINK_W = 2;

   // register offsets on the host register port
   localparam logic [ADDR_W-1:0] CMD_CTRL_OFS = 7'h00;
   localparam logic [ADDR_W-1:0] BUS_CTRL_OFS = 7'h01;

   // command_control fields
   localparam int CMD_POWER_DOWN_BIT = 7;
   localparam int CMD_RADIO_OFF_BIT = 6;
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_CODE_MSB = 4;

   // bus_access_control fields
   localparam int BUS_UNLOCK_BIT = 7;
   localparam int BUS_HOST_BIT = 6;
   localparam int BUS_MODULE_BIT = 5;
   localparam int BUS_LINK_LSB = 2;
   localparam int BUS_LINK_MSB = 3;

   // command codes known to this block; other codes are passed through
   localparam logic [CMD_W-1:0] CMD_IDLE = 5'h00;

   // module link select encodings
   localparam logic [LINK_W-1:0] LINK_OFF = 2'h0;
   localparam logic [LINK_W-1:0] LINK_SPI = 2'h1;
   localparam logic [LINK_W-1:0] LINK_TWO_WIRE_LOW = 2'h2;
   localparam logic [LINK_W-1:0] LINK_TWO_WIRE = 2'h3;

   // values after reset
   localparam logic RST_POWER_DOWN = 1'b0;
   localparam logic RST_RADIO_OFF = 1'b0;
   localparam logic RST_UNLOCK = 1'b0;
   localparam logic RST_GRANT_HOST = 1'b1;
   localparam logic RST_GRANT_MODULE = 1'b0;
   localparam logic [LINK_W-1:0] RST_LINK = 2'h0;
   localparam logic [DATA_W-1:0] RST_RD_DATA = 8'h00;

   typedef enum logic [0:0] {
      CBAC_CMD_IDLE = 1'b0,
      CBAC_CMD_RUN = 1'b1
   } cbac_cmd_state_t;

endpackage : cbac_pkg

// [verilog/cbac_link_decode.sv]
`timescale 1ns/1ps

module cbac_link_decode (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [cbac_pkg::LINK_W-1:0] linkSelect,
   output logic linkSpiEn,
   output logic linkTwoWireLowEn,
   output logic linkTwoWireEn
);

   logic next_linkSpiEn;
   logic next_linkTwoWireLowEn;
   logic next_linkTwoWireEn;

   // one-hot enables so that never two link engines run at once
   always_comb begin
      next_linkSpiEn = (linkSelect == cbac_pkg::LINK_SPI);
      next_linkTwoWireLowEn = (linkSelect == cbac_pkg::LINK_TWO_WIRE_LOW);
      next_linkTwoWireEn = (linkSelect == cbac_pkg::LINK_TWO_WIRE);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         linkSpiEn <= 1'b0;
         linkTwoWireLowEn <= 1'b0;
         linkTwoWireEn <= 1'b0;
      end else begin
         linkSpiEn <= next_linkSpiEn;
         linkTwoWireLowEn <= next_linkTwoWireLowEn;
         linkTwoWireEn <= next_linkTwoWireEn;
      end
   end

endmodule : cbac_link_decode

// [verilog/cbac_control.sv]
`timescale 1ns/1ps

module cbac_control (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [cbac_pkg::ADDR_W-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [cbac_pkg::DATA_W-1:0] regWrData,
   output logic [cbac_pkg::DATA_W-1:0] regRdData,
   output logic regRdValid,
   input wire logic cmdDone,
   input wire logic wakeEvent,
   output logic powerDown,
   output logic rxPowerDown,
   output logic txPowerDown,
   output logic [cbac_pkg::CMD_W-1:0] cmdCode,
   output logic cmdStart,
   output logic cmdStop,
   output logic cmdActive,
   output logic grantToHost,
   output logic grantToModule,
   output logic linkSpiEn,
   output logic linkTwoWireLowEn,
   output logic linkTwoWireEn
);

   cbac_pkg::cbac_cmd_state_t cmdState;
   cbac_pkg::cbac_cmd_state_t next_cmdState;

   logic radioOff;
   logic ownershipUnlock;
   logic [cbac_pkg::LINK_W-1:0] moduleLinkSelect;

   logic next_powerDown;
   logic next_radioOff;
   logic [cbac_pkg::CMD_W-1:0] next_cmdCode;
   logic next_cmdStart;
   logic next_cmdStop;
   logic next_ownershipUnlock;
   logic next_grantToHost;
   logic next_grantToModule;
   logic [cbac_pkg::LINK_W-1:0] next_moduleLinkSelect;
   logic [cbac_pkg::DATA_W-1:0] next_regRdData;

   logic wrCmd;
   logic wrBus;
   logic [cbac_pkg::CMD_W-1:0] wrCode;
   logic wrAsksHost;
   logic wrAsksModule;

   assign wrCmd = regWrEn && (regAddr == cbac_pkg::CMD_CTRL_OFS);
   assign wrBus = regWrEn && (regAddr == cbac_pkg::BUS_CTRL_OFS);
   assign wrCode = regWrData[cbac_pkg::CMD_CODE_MSB:cbac_pkg::CMD_CODE_LSB];
   assign wrAsksHost = regWrData[cbac_pkg::BUS_HOST_BIT];
   assign wrAsksModule = regWrData[cbac_pkg::BUS_MODULE_BIT];

   // ---------------- command register and command sequencing ----------------
   always_comb begin
      next_cmdState = cmdState;
      next_cmdCode = cmdCode;
      next_cmdStart = 1'b0;
      next_cmdStop = 1'b0;
      next_powerDown = powerDown;
      next_radioOff = radioOff;

      // a wake event ends power-down; a command_control write in the same cycle wins
      if (wakeEvent) begin
         next_powerDown = 1'b0;
      end
      if (wrCmd) begin
         next_powerDown = regWrData[cbac_pkg::CMD_POWER_DOWN_BIT];
         next_radioOff = regWrData[cbac_pkg::CMD_RADIO_OFF_BIT];
      end

      unique case (cmdState)
         cbac_pkg::CBAC_CMD_IDLE: begin
            if (wrCmd && (wrCode != cbac_pkg::CMD_IDLE)) begin
               next_cmdCode = wrCode;
               next_cmdStart = 1'b1;
               next_cmdState = cbac_pkg::CBAC_CMD_RUN;
            end else if (wrCmd) begin
               next_cmdCode = cbac_pkg::CMD_IDLE;
            end
         end
         cbac_pkg::CBAC_CMD_RUN: begin
            if (wrCmd && (wrCode == cbac_pkg::CMD_IDLE)) begin
               // idle code written while busy aborts the running command
               next_cmdCode = cbac_pkg::CMD_IDLE;
               next_cmdStop = 1'b1;
               next_cmdState = cbac_pkg::CBAC_CMD_IDLE;
            end else if (wrCmd) begin
               // a new code replaces the old one even if done arrives now
               next_cmdCode = wrCode;
               next_cmdStart = 1'b1;
            end else if (cmdDone) begin
               next_cmdCode = cbac_pkg::CMD_IDLE;
               next_cmdState = cbac_pkg::CBAC_CMD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmdState <= cbac_pkg::CBAC_CMD_IDLE;
         cmdCode <= cbac_pkg::CMD_IDLE;
         cmdStart <= 1'b0;
         cmdStop <= 1'b0;
         cmdActive <= 1'b0;
         powerDown <= cbac_pkg::RST_POWER_DOWN;
         radioOff <= cbac_pkg::RST_RADIO_OFF;
         rxPowerDown <= cbac_pkg::RST_RADIO_OFF;
         txPowerDown <= cbac_pkg::RST_RADIO_OFF;
      end else begin
         cmdState <= next_cmdState;
         cmdCode <= next_cmdCode;
         cmdStart <= next_cmdStart;
         cmdStop <= next_cmdStop;
         cmdActive <= (next_cmdState == cbac_pkg::CBAC_CMD_RUN);
         powerDown <= next_powerDown;
         radioOff <= next_radioOff;
         rxPowerDown <= next_radioOff;
         txPowerDown <= next_radioOff;
      end
   end

   // ---------------- bus ownership and module link ----------------
   always_comb begin
      next_ownershipUnlock = ownershipUnlock;
      next_grantToHost = grantToHost;
      next_grantToModule = grantToModule;
      next_moduleLinkSelect = moduleLinkSelect;

      if (regWrEn) begin
         if (ownershipUnlock) begin
            // unlock is spent by any write, whatever the address
            next_ownershipUnlock = 1'b0;
         end else begin
            next_ownershipUnlock = wrBus && regWrData[cbac_pkg::BUS_UNLOCK_BIT];
         end
      end

      if (wrBus) begin
         next_moduleLinkSelect = regWrData[cbac_pkg::BUS_LINK_MSB:cbac_pkg::BUS_LINK_LSB];
         // ownership only moves on the write right after the unlock write
         if (ownershipUnlock && !(wrAsksHost && wrAsksModule)) begin
            next_grantToHost = wrAsksHost;
            next_grantToModule = wrAsksModule;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ownershipUnlock <= cbac_pkg::RST_UNLOCK;
         grantToHost <= cbac_pkg::RST_GRANT_HOST;
         grantToModule <= cbac_pkg::RST_GRANT_MODULE;
         moduleLinkSelect <= cbac_pkg::RST_LINK;
      end else begin
         ownershipUnlock <= next_ownershipUnlock;
         grantToHost <= next_grantToHost;
         grantToModule <= next_grantToModule;
         moduleLinkSelect <= next_moduleLinkSelect;
      end
   end

   cbac_link_decode u_link_decode (
      .core_clk(core_clk),
      .srst(srst),
      .linkSelect(moduleLinkSelect),
      .linkSpiEn(linkSpiEn),
      .linkTwoWireLowEn(linkTwoWireLowEn),
      .linkTwoWireEn(linkTwoWireEn)
   );

   // ---------------- read path ----------------
   // reserved bits and unmapped addresses read as zero
   always_comb begin
      next_regRdData = cbac_pkg::RST_RD_DATA;
      if (regRdEn) begin
         unique case (regAddr)
            cbac_pkg::CMD_CTRL_OFS: begin
               next_regRdData[cbac_pkg::CMD_POWER_DOWN_BIT] = powerDown;
               next_regRdData[cbac_pkg::CMD_RADIO_OFF_BIT] = radioOff;
               next_regRdData[cbac_pkg::CMD_CODE_MSB:cbac_pkg::CMD_CODE_LSB] = cmdCode;
            end
            cbac_pkg::BUS_CTRL_OFS: begin
               next_regRdData[cbac_pkg::BUS_UNLOCK_BIT] = ownershipUnlock;
               next_regRdData[cbac_pkg::BUS_HOST_BIT] = grantToHost;
               next_regRdData[cbac_pkg::BUS_MODULE_BIT] = grantToModule;
               next_regRdData[cbac_pkg::BUS_LINK_MSB:cbac_pkg::BUS_LINK_LSB] = moduleLinkSelect;
            end
            default: begin
               next_regRdData = cbac_pkg::RST_RD_DATA;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         regRdData <= cbac_pkg::RST_RD_DATA;
         regRdValid <= 1'b0;
      end else begin
         regRdData <= next_regRdData;
         regRdValid <= regRdEn;
      end
   end

endmodule : cbac_control

// [dv/cbac_control_sva.sv]
`timescale 1ns/1ps
module cbac_control_sva (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [cbac_pkg::ADDR_W-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [cbac_pkg::DATA_W-1:0] regWrData,
   input wire logic [cbac_pkg::DATA_W-1:0] regRdData,
   input wire logic regRdValid,
   input wire logic cmdDone,
   input wire logic wakeEvent,
   input wire logic powerDown,
   input wire logic rxPowerDown,
   input wire logic txPowerDown,
   input wire logic [cbac_pkg::CMD_W-1:0] cmdCode,
   input wire logic cmdStart,
   input wire logic cmdStop,
   input wire logic cmdActive,
   input wire logic grantToHost,
   input wire logic grantToModule,
   input wire logic linkSpiEn,
   input wire logic linkTwoWireLowEn,
   input wire logic linkTwoWireEn
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic unl;
   logic cmdWr;
   logic busWr;
   assign cmdWr = regWrEn && regAddr == cbac_pkg::CMD_CTRL_OFS;
   assign busWr = regWrEn && regAddr == cbac_pkg::BUS_CTRL_OFS;
   // shadow of the unlock bit; any write spends it
   always_ff @(posedge core_clk)
      if (srst) unl <= 1'b0;
      else if (regWrEn) unl <= !unl && busWr && regWrData[7];
   grant_excl_a: assert property (!(grantToHost && grantToModule))
      else $error("both grants high");
   pwr_set_a: assert property (cmdWr && regWrData[7] |=> powerDown)
      else $error("power-down not set");
   radio_pair_a: assert property (cmdWr |=> rxPowerDown == $past(regWrData[6])
      && txPowerDown == $past(regWrData[6])) else $error("radio power-down wrong");
   cmd_load_a: assert property (cmdWr |=> cmdCode == $past(regWrData[4:0]))
      else $error("command code not loaded");
   cmd_start_a: assert property (cmdWr && regWrData[4:0] != 5'h00 |=> cmdStart)
      else $error("no start pulse");
   cmd_done_a: assert property (cmdActive && cmdDone && !cmdWr |=>
      cmdCode == cbac_pkg::CMD_IDLE && !cmdActive) else $error("command not idled");
   grant_locked_a: assert property (regWrEn && !unl |=>
      $stable(grantToHost) && $stable(grantToModule)) else $error("locked grant moved");
   grant_take_a: assert property (busWr && unl && regWrData[6:5] != 2'h3 |=>
      {grantToHost, grantToModule} == $past(regWrData[6:5])) else $error("grant not taken");
   link_dec_a: assert property (busWr |-> ##2
      linkSpiEn == ($past(regWrData[3:2], 2) == cbac_pkg::LINK_SPI)
      && linkTwoWireLowEn == ($past(regWrData[3:2], 2) == cbac_pkg::LINK_TWO_WIRE_LOW)
      && linkTwoWireEn == ($past(regWrData[3:2], 2) == cbac_pkg::LINK_TWO_WIRE))
      else $error("link enables wrong");
   cmd_stop_a: assert property (cmdActive && cmdWr && regWrData[4:0] == 5'h00 |=>
      cmdStop && !cmdActive && cmdCode == cbac_pkg::CMD_IDLE) else $error("no stop on idle code");
   idle_quiet_a: assert property (!cmdActive && cmdWr && regWrData[4:0] == 5'h00 |=>
      !cmdStart) else $error("start pulse on idle code");
   cover property (cmdActive && cmdDone);
   cover property (cmdStop);
   cover property (busWr && unl && regWrData[5]);
   cover property (linkTwoWireLowEn);
endmodule : cbac_control_sva

// [dv/cbac_host_model.sv]
`timescale 1ns/1ps
module cbac_host_model (
   input wire logic core_clk,
   output logic [cbac_pkg::ADDR_W-1:0] regAddr,
   output logic regWrEn,
   output logic regRdEn,
   output logic [cbac_pkg::DATA_W-1:0] regWrData,
   input wire logic [cbac_pkg::DATA_W-1:0] regRdData,
   input wire logic regRdValid
);
   initial begin
      regAddr = 7'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regWrData = 8'h00;
   end
   // released lines show the inverse so stale values are never trusted
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge core_clk);
      regAddr = a;
      regWrData = d & (a == cbac_pkg::BUS_CTRL_OFS ? 8'hec : 8'hdf);
      regWrEn = 1'b1;
      @(negedge core_clk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~regWrData;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] q, output logic v);
      @(negedge core_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge core_clk);
      regRdEn = 1'b0;
      q = regRdData;
      v = regRdValid;
      regAddr = ~a;
   endtask : rd
endmodule : cbac_host_model

// [dv/tb_command_and_bus_access_control.sv]
`timescale 1ns/1ps
module tb_command_and_bus_access_control;
   logic core_clk, srst, regWrEn, regRdEn, regRdValid, cmdDone, wakeEvent, powerDown;
   logic rxPowerDown, txPowerDown, cmdStart, cmdStop, cmdActive, grantToHost, grantToModule;
   logic linkSpiEn, linkTwoWireLowEn, linkTwoWireEn, v;
   logic [6:0] regAddr;
   logic [7:0] regWrData, regRdData, q;
   logic [4:0] cmdCode, code;
   logic r;
   int errCount = 0;
   int cmpCount = 0;
   cbac_control DUT (.core_clk, .srst, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
      .regRdValid, .cmdDone, .wakeEvent, .powerDown, .rxPowerDown, .txPowerDown, .cmdCode,
      .cmdStart, .cmdStop, .cmdActive, .grantToHost, .grantToModule, .linkSpiEn,
      .linkTwoWireLowEn, .linkTwoWireEn);
   cbac_host_model host (.core_clk, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
      .regRdValid);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [7:0] expBus(input logic u, h, m, input logic [1:0] l);
      return {u, h, m, 1'b0, l, 2'h0};
   endfunction : expBus
   function automatic logic [2:0] linkExp(input logic [1:0] s);
      return {s == 2'h1, s == 2'h2, s == 2'h3};
   endfunction : linkExp
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      cmpCount++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic printVerdict;
      $display("checks %0d mismatches %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : printVerdict
   initial begin
      #200000;
      errCount++;
      printVerdict();
   end
   initial begin
      srst = 1'b1;
      cmdDone = 1'b0;
      wakeEvent = 1'b0;
      void'($urandom(48));
      repeat (8) @(negedge core_clk);
      srst = 1'b0;
      host.rd(7'h01, q, v);
      chk(q, expBus(0, 1, 0, 2'h0), "reset bus reg");
      chk(v, 1, "read valid");
      $display("reset test done");
      repeat (8) begin
         code = 5'($urandom_range(1, 31));
         r = 1'($urandom);
         host.wr(7'h00, {1'b0, r, 1'b0, code});
         chk(cmdCode, code, "cmd code");
         chk(cmdStart, 1, "cmd start");
         chk({rxPowerDown, txPowerDown}, {r, r}, "radio off");
         cmdDone = 1'b1;
         @(negedge core_clk);
         cmdDone = 1'b0;
         chk({cmdActive, cmdCode}, 0, "cmd idle");
      end
      host.wr(7'h00, 8'h80);
      chk(powerDown, 1, "power down");
      wakeEvent = 1'b1;
      @(negedge core_clk);
      wakeEvent = 1'b0;
      chk(powerDown, 0, "wake");
      // a new code while busy restarts, the idle code while busy aborts
      host.wr(7'h00, 8'h03);
      host.wr(7'h00, 8'h05);
      chk({cmdStart, cmdActive, cmdCode}, 8'h65, "cmd restart");
      host.wr(7'h00, 8'h00);
      chk({cmdStop, cmdActive, cmdCode}, 8'h40, "cmd abort");
      $display("command test done");
      host.wr(7'h01, 8'h20);
      chk({grantToHost, grantToModule}, 2'h2, "locked write");
      host.wr(7'h01, 8'h80);
      host.rd(7'h01, q, v);
      chk(q, expBus(1, 1, 0, 2'h0), "unlock set");
      host.wr(7'h01, 8'h24);
      chk({grantToHost, grantToModule}, 2'h1, "module grant");
      host.rd(7'h01, q, v);
      chk(q, expBus(0, 0, 1, 2'h1), "unlock spent");
      for (int i = 0; i < 4; i++) begin
         host.wr(7'h01, {4'h0, 2'(i), 2'h0});
         @(negedge core_clk);
         chk({linkSpiEn, linkTwoWireLowEn, linkTwoWireEn}, linkExp(2'(i)), "link");
      end
      host.wr(7'h01, 8'h80);
      host.wr(7'h01, 8'h60); // both asked on purpose
      chk({grantToHost, grantToModule}, 2'h1, "both refused");
      host.wr(7'h01, 8'h80);
      host.wr(7'h00, 8'h00);
      host.wr(7'h01, 8'h40);
      chk({grantToHost, grantToModule}, 2'h1, "spent unlock");
      host.wr(7'h01, 8'h80);
      host.wr(7'h01, 8'h40);
      chk({grantToHost, grantToModule}, 2'h2, "host grant");
      $display("ownership test done");
      repeat (30) begin
         host.wr(7'($urandom_range(0, 2)), 8'($urandom));
         chk(grantToHost && grantToModule, 0, "random exclusive");
      end
      host.rd(7'h05, q, v);
      chk(q, 0, "unmapped read");
      $display("random test done");
      printVerdict();
   end
endmodule : tb_command_and_bus_access_control
bind cbac_control cbac_control_sva chk_i (.core_clk, .srst, .regAddr, .regWrEn, .regRdEn,
   .regWrData, .regRdData, .regRdValid, .cmdDone, .wakeEvent, .powerDown, .rxPowerDown,
   .txPowerDown, .cmdCode, .cmdStart, .cmdStop, .cmdActive, .grantToHost, .grantToModule,
   .linkSpiEn, .linkTwoWireLowEn, .linkTwoWireEn);
